// ===== design/bscan_cfg.svh
// offsets, field positions, reset values and opcodes of the test port
`ifndef BSCAN_CFG_SVH
`define BSCAN_CFG_SVH
`define OFF_RCS 8'h00
`define OFF_PORT 8'h04
`define OFF_DIR 8'h08
`define OFF_PIN 8'h0c
`define OFF_CTRL 8'h10
`define OFF_LATCH 8'h14
`define FLAG_BIT 4
`define PUD_BIT 0
`define IR_W 4
`define IR_IDCODE 4'h1
`define IR_SAMPLE 4'h2
`define IR_DEVRST 4'hc
`define IR_CAPTURE 4'h1
`define ID_W 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REG8_RST 8'h00
`endif

// ===== design/bscan_pkg.sv
// types of the test port
package bscan_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } tap_state_type;
endpackage : bscan_pkg

// ===== design/boundary_scan_instructions.sv
// test port data registers, boundary chain, device reset, register slave
// Notes on behaviour
// (RL1) identification capture loads the id value
// (RL2) identification shift moves one bit per clock
// (RL3) opcode 0x2 selects boundary chain, no disturbance
// (RL4) sample capture takes external pin levels
// (RL5) sample shift moves chain one cell
// (RL6) sample update fills latches, pins untouched
// (RL7) opcode 0xc resets device, not tap
// (RL8) reset instruction selects one-bit reset register
// (RL9) reset held while register holds one
// (RL10) reset from register sets status bit 4
// (RL11) flag cleared by power-on or writing zero
// (RL12) pin: pull-up cell plus two-stage cell
// (RL13) scanned input taken before pin register
// (RL14) output data is port, control is direction
// (RL15) pull-up is not pud, not dir, port
// (RL16) alternate functions sit outside the chain
// (RL17) analog boundary observed by scan cells
// (RL18) instruction register is four bits
// (RL19) all shift registers lsb first
// (RL20) opcode 0x1 id register, default at reset
// (RL21) other opcodes select one-bit bypass
`timescale 1ns/1ns
`include "bscan_cfg.svh"
module boundary_scan_instructions #(
  parameter int NPINS = 8,
  parameter int NANA = 2,
  parameter logic [31:0] IDCODE = 32'h0000_0001 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [NPINS-1:0] pin_in_i,
  output logic [NPINS-1:0] pin_out_o,
  output logic [NPINS-1:0] pin_oe_o,
  output logic [NPINS-1:0] pin_pullup_o,
  input wire logic [NANA-1:0] ana_cmp_i,
  output logic dev_reset_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CH = 3 * NPINS + NANA;

  bscan_pkg::tap_state_type state_ff, nxt_state;
  logic tck_s1_ff, tck_s2_ff, tck_d_ff;
  logic tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff;
  logic [NPINS-1:0] pin_s1_ff, pin_s2_ff, pin_reg_ff;
  logic [NANA-1:0] ana_s1_ff, ana_s2_ff;
  logic rise, fall, cap_dr, sh_dr, upd_dr;
  logic [`IR_W-1:0] ir_ff, ir_sh_ff;
  logic [`ID_W-1:0] id_ff;
  logic [CH-1:0] bs_ff, latch_ff;
  logic bypass_ff, rst_reg_ff, tdo_ff, tdo_oe_ff;
  logic sel_id, sel_bs, sel_rst, sel_byp;
  logic [NPINS-1:0] port_ff, dir_ff, pue_ff;
  logic pud_ff, flag_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff, rdata_ff, rd_data;
  logic [3:0] ws_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_en, wr_ok, rd_ok;
  logic [CH+31:0] lat_ext;

  // link inputs through two flops, then edge detect
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      tck_d_ff <= 1'b0;
      tms_s1_ff <= 1'b1;
      tms_s2_ff <= 1'b1;
      tdi_s1_ff <= 1'b1;
      tdi_s2_ff <= 1'b1;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_reg_ff <= '0;
      ana_s1_ff <= '0;
      ana_s2_ff <= '0;
    end
    else
    begin
      tck_s1_ff <= tck_i;
      tck_s2_ff <= tck_s1_ff;
      tck_d_ff <= tck_s2_ff;
      tms_s1_ff <= tms_i;
      tms_s2_ff <= tms_s1_ff;
      tdi_s1_ff <= tdi_i;
      tdi_s2_ff <= tdi_s1_ff;
      pin_s1_ff <= pin_in_i;
      pin_s2_ff <= pin_s1_ff;
      pin_reg_ff <= pin_s2_ff; // port pin register stage
      ana_s1_ff <= ana_cmp_i;
      ana_s2_ff <= ana_s1_ff;
    end
  end

  assign rise = tck_s2_ff & ~tck_d_ff;
  assign fall = ~tck_s2_ff & tck_d_ff;
  assign cap_dr = rise && (state_ff == bscan_pkg::CAP_DR);
  assign sh_dr = rise && (state_ff == bscan_pkg::SH_DR);
  assign upd_dr = rise && (state_ff == bscan_pkg::UPD_DR);
  assign sel_id = (ir_ff == `IR_IDCODE);
  assign sel_bs = (ir_ff == `IR_SAMPLE);
  assign sel_rst = (ir_ff == `IR_DEVRST);
  assign sel_byp = !(sel_id || sel_bs || sel_rst); // [RL21]

  // tap sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      bscan_pkg::TLR: nxt_state = tms_s2_ff ? bscan_pkg::TLR : bscan_pkg::RTI;
      bscan_pkg::RTI: nxt_state = tms_s2_ff ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
      bscan_pkg::SEL_DR: nxt_state = tms_s2_ff ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
      bscan_pkg::CAP_DR: nxt_state = tms_s2_ff ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::SH_DR: nxt_state = tms_s2_ff ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
      bscan_pkg::EX1_DR: nxt_state = tms_s2_ff ? bscan_pkg::UPD_DR : bscan_pkg::PA_DR;
      bscan_pkg::PA_DR: nxt_state = tms_s2_ff ? bscan_pkg::EX2_DR : bscan_pkg::PA_DR;
      bscan_pkg::EX2_DR: nxt_state = tms_s2_ff ? bscan_pkg::UPD_DR : bscan_pkg::SH_DR;
      bscan_pkg::UPD_DR: nxt_state = tms_s2_ff ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
      bscan_pkg::SEL_IR: nxt_state = tms_s2_ff ? bscan_pkg::TLR : bscan_pkg::CAP_IR;
      bscan_pkg::CAP_IR: nxt_state = tms_s2_ff ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::SH_IR: nxt_state = tms_s2_ff ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
      bscan_pkg::EX1_IR: nxt_state = tms_s2_ff ? bscan_pkg::UPD_IR : bscan_pkg::PA_IR;
      bscan_pkg::PA_IR: nxt_state = tms_s2_ff ? bscan_pkg::EX2_IR : bscan_pkg::PA_IR;
      bscan_pkg::EX2_IR: nxt_state = tms_s2_ff ? bscan_pkg::UPD_IR : bscan_pkg::SH_IR;
      bscan_pkg::UPD_IR: nxt_state = tms_s2_ff ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_ff <= bscan_pkg::TLR;
    else if (rise)
      state_ff <= nxt_state;
  end

  // instruction register, four bits, lsb first
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ir_sh_ff <= `IR_CAPTURE;
      ir_ff <= `IR_IDCODE; // [RL20]
    end
    else if (rise)
    begin
      if (state_ff == bscan_pkg::TLR)
        ir_ff <= `IR_IDCODE; // [RL20]
      else if (state_ff == bscan_pkg::CAP_IR)
        ir_sh_ff <= `IR_CAPTURE;
      else if (state_ff == bscan_pkg::SH_IR)
        ir_sh_ff <= {tdi_s2_ff, ir_sh_ff[`IR_W-1:1]}; // [RL18] [RL19]
      else if (state_ff == bscan_pkg::UPD_IR)
        ir_ff <= ir_sh_ff; // [RL18]
    end
  end

  // identification and bypass registers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      id_ff <= '0;
      bypass_ff <= 1'b0;
    end
    else
    begin
      if (cap_dr && sel_id)
        id_ff <= IDCODE; // [RL1]
      else if (sh_dr && sel_id)
        id_ff <= {tdi_s2_ff, id_ff[`ID_W-1:1]}; // [RL2] [RL19]
      if (cap_dr && sel_byp)
        bypass_ff <= 1'b0; // [RL21]
      else if (sh_dr && sel_byp)
        bypass_ff <= tdi_s2_ff; // [RL21]
    end
  end

  // boundary chain: per pin {pull-up, control, data}, analog cells on top
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bs_ff <= '0;
      latch_ff <= '0;
    end
    else
    begin
      if (cap_dr && sel_bs)
      begin
        for (int i = 0; i < NPINS; i++)
        begin
          bs_ff[3*i] <= pin_s2_ff[i]; // [RL4] [RL12] [RL13]
          bs_ff[3*i+1] <= dir_ff[i]; // [RL14]
          bs_ff[3*i+2] <= pue_ff[i]; // [RL12] [RL15]
        end
        for (int j = 0; j < NANA; j++)
          bs_ff[3*NPINS+j] <= ana_s2_ff[j]; // [RL17]
      end
      else if (sh_dr && sel_bs)
        bs_ff <= {tdi_s2_ff, bs_ff[CH-1:1]}; // [RL5] [RL19]
      if (upd_dr && sel_bs)
        latch_ff <= bs_ff; // [RL3] [RL6]
    end
  end

  // device reset register, not latched, tap keeps running
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_reg_ff <= 1'b0;
    else if (sh_dr && sel_rst)
      rst_reg_ff <= tdi_s2_ff; // [RL7] [RL8]
  end

  assign dev_reset_o = rst_reg_ff; // [RL9]

  // serial output changes on falling test clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (fall)
    begin
      tdo_oe_ff <= (state_ff == bscan_pkg::SH_DR) || (state_ff == bscan_pkg::SH_IR);
      if (state_ff == bscan_pkg::SH_IR)
        tdo_ff <= ir_sh_ff[0];
      else if (sel_id)
        tdo_ff <= id_ff[0];
      else if (sel_bs)
        tdo_ff <= bs_ff[0];
      else if (sel_rst)
        tdo_ff <= rst_reg_ff;
      else
        tdo_ff <= bypass_ff;
    end
  end

  assign tdo_o = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;

  // port logic; alternate functions would join outside the chain [RL16]
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pue_ff <= '0;
    else
      pue_ff <= {NPINS{~pud_ff}} & ~dir_ff & port_ff; // [RL15]
  end

  assign pin_out_o = port_ff; // [RL6] [RL14]
  assign pin_oe_o = dir_ff;
  assign pin_pullup_o = pue_ff;

  // register slave write path
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign wr_en = aw_ff && w_ff && !bvalid_ff;
  assign wr_ok = (awa_ff == `OFF_RCS) || (awa_ff == `OFF_PORT) ||
                 (awa_ff == `OFF_DIR) || (awa_ff == `OFF_CTRL);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (wr_en)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      port_ff <= '0;
      dir_ff <= '0;
      pud_ff <= 1'b0;
    end
    else if (wr_en && ws_ff[0])
    begin
      if (awa_ff == `OFF_PORT)
        port_ff <= wd_ff[NPINS-1:0];
      if (awa_ff == `OFF_DIR)
        dir_ff <= wd_ff[NPINS-1:0];
      if (awa_ff == `OFF_CTRL)
        pud_ff <= wd_ff[`PUD_BIT];
    end
  end

  // status flag: only power-on reset or a written zero clears, set wins
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flag_ff <= 1'b0; // [RL11]
    else if (rst_reg_ff)
      flag_ff <= 1'b1; // [RL10]
    else if (wr_en && ws_ff[0] && (awa_ff == `OFF_RCS) && !wd_ff[`FLAG_BIT])
      flag_ff <= 1'b0; // [RL11]
  end

  // register slave read path
  assign lat_ext = {32'h0, latch_ff};
  always_comb
  begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `OFF_RCS: rd_data[`FLAG_BIT] = flag_ff;
      `OFF_PORT: rd_data[NPINS-1:0] = port_ff;
      `OFF_DIR: rd_data[NPINS-1:0] = dir_ff;
      `OFF_PIN: rd_data[NPINS-1:0] = pin_reg_ff;
      `OFF_CTRL: rd_data[`PUD_BIT] = pud_ff;
      `OFF_LATCH: rd_data = lat_ext[31:0];
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  a_id_capture: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL1]
    cap_dr && sel_id |=> id_ff == IDCODE) else $error("id capture wrong");
  a_id_shift_lsb: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL2]
    sh_dr && sel_id |=> id_ff == {$past(tdi_s2_ff), $past(id_ff[`ID_W-1:1])})
    else $error("id shift wrong");
  a_bs_capture_pin: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL4]
    cap_dr && sel_bs |=> bs_ff[0] == $past(pin_s2_ff[0]) && bs_ff[1] == $past(dir_ff[0]))
    else $error("pin capture wrong");
  a_bs_shift_cell: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL5]
    sh_dr && sel_bs |=> bs_ff[CH-1] == $past(tdi_s2_ff) && bs_ff[0] == $past(bs_ff[1]))
    else $error("chain shift wrong");
  a_preload_pins_kept: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL6]
    upd_dr && sel_bs && !wr_en |=> latch_ff == $past(bs_ff) && $stable(pin_out_o))
    else $error("preload disturbed pins");
  a_reset_reg_load: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL8]
    sh_dr && sel_rst |=> dev_reset_o == $past(tdi_s2_ff)) else $error("reset reg wrong");
  a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL10]
    rst_reg_ff |=> flag_ff) else $error("flag not set");
  a_flag_sw_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL11]
    !rst_reg_ff && wr_en && ws_ff[0] && awa_ff == `OFF_RCS && !wd_ff[`FLAG_BIT]
    |=> !flag_ff) else $error("flag not cleared");
  a_pullup_term: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL15]
    ##1 pin_pullup_o == ($past({NPINS{~pud_ff}}) & ~$past(dir_ff) & $past(port_ff)))
    else $error("pull-up term wrong");
  a_ir_default_id: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL20]
    rise && state_ff == bscan_pkg::TLR |=> ir_ff == `IR_IDCODE) else $error("ir default");
endmodule : boundary_scan_instructions

// ===== sim/tap_tester.sv
// test controller model on the four-wire test port
`timescale 1ns/1ns
module tap_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic smp, oe_smp, oe_all;
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // lines set in low phase, tdo taken before the rise
  task automatic pulse(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    #400;
    smp = tdo_i;
    oe_smp = tdo_oe_i;
    tck_o = 1'b1;
    #400;
    tck_o = 1'b0;
  endtask : pulse
  // tdi toggles outside shifting
  task automatic nav(input logic m);
    pulse(m, ~tdi_o);
  endtask : nav
  task automatic go_idle();
    // test clock edges kept on the 100 ns grid of the falling system clock
    if ($time % 100 != 0)
      #(100 - $time % 100);
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask : go_idle
  // idle, capture, shift n bits, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = '0;
    oe_all = 1'b1;
    if ($time % 100 != 0)
      #(100 - $time % 100);
    nav(1'b1);
    if (ir)
      nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i]);
      dout[i] = smp;
      oe_all = oe_all & oe_smp;
    end
    nav(1'b1);
    nav(1'b0);
  endtask : scan
  task automatic load_ir(input logic [3:0] op, output logic [3:0] cap);
    logic [31:0] o;
    scan(1'b1, 4, {28'h0, op}, o);
    cap = o[3:0];
  endtask : load_ir
endmodule : tap_tester

// ===== sim/test_boundary_scan_instructions.sv
// self-checking bench for the test port data registers
`timescale 1ns/1ns
`include "bscan_cfg.svh"
module test_boundary_scan_instructions;
  localparam int NP = 8;
  localparam int NA = 2;
  localparam int BL = 3 * NP + NA;
  localparam logic [31:0] FL = 32'h1 << `FLAG_BIT;
  localparam logic [31:0] ID = 32'h3c5a_96e1; // arbitrary value
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, dev_rst, awready, wready, bvalid, arready, rvalid;
  logic [NP-1:0] pin_in = '0;
  logic [NP-1:0] pin_out, pin_oe, pin_pu;
  logic [NA-1:0] ana = '0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] offs [4] = '{`OFF_RCS, `OFF_PORT, `OFF_DIR, `OFF_CTRL};
  logic [3:0] byp [3] = '{4'h3, 4'h7, 4'hf};
  int errors = 0;
  int checked = 0;
  integer seed = 32'h19f0;
  always #50 clk_i = ~clk_i;
  tap_tester tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  boundary_scan_instructions #(.NPINS(NP), .NANA(NA), .IDCODE(ID)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pin_pullup_o(pin_pu), .ana_cmp_i(ana), .dev_reset_o(dev_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_i);
      if (awready === 1'b1)
        aw_ok = 1'b1;
      if (wready === 1'b1)
        w_ok = 1'b1;
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check(rresp, er);
  endtask : rchk
  // whole run is about 2000 clocks
  initial
  begin
    #2000000;
    errors++;
    end_sim();
  end
  initial
  begin
    logic [31:0] o, e, pm, dm, um, im, am, pre;
    logic [3:0] c;
    logic [1:0] r;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (offs[k])
      rchk(offs[k], `REG8_RST, `RESP_OKAY);
    tst.go_idle();
    tst.scan(1'b0, `ID_W, $random(seed), o);
    check(o, ID);
    $display("test identification done");
    for (int k = 0; k < 3; k++)
    begin
      tst.load_ir(byp[k], c);
      check(c, `IR_CAPTURE);
      pre = $random(seed);
      tst.scan(1'b0, 8, pre, o);
      check(o[7:0], {pre[6:0], 1'b0});
    end
    $display("test bypass done");
    pm = $random(seed);
    dm = $random(seed);
    um = $random(seed);
    im = $random(seed);
    am = $random(seed);
    pre = $random(seed);
    wr(`OFF_PORT, pm, r);
    wr(`OFF_DIR, dm, r);
    wr(`OFF_CTRL, {31'h0, um[0]}, r);
    pin_in <= im[NP-1:0];
    ana <= am[NA-1:0];
    repeat (4) @(posedge clk_i);
    e = '0;
    for (int i = 0; i < NP; i++)
    begin
      e[3 * i] = im[i];
      e[3 * i + 1] = dm[i];
      e[3 * i + 2] = ~um[0] & ~dm[i] & pm[i];
    end
    e[3 * NP +: NA] = am[NA-1:0];
    check(pin_pu, ~{NP{um[0]}} & ~dm[NP-1:0] & pm[NP-1:0]);
    rchk(`OFF_PIN, im[NP-1:0], `RESP_OKAY);
    tst.load_ir(`IR_SAMPLE, c);
    tst.scan(1'b0, BL, pre, o);
    check(o[BL-1:0], e[BL-1:0]);
    check(tst.oe_all, 1'b1);
    check(tdo_oe, 1'b0);
    check(pin_out, pm[NP-1:0]);
    check(pin_oe, dm[NP-1:0]);
    rchk(`OFF_LATCH, pre[BL-1:0], `RESP_OKAY);
    $display("test sample done");
    tst.load_ir(`IR_DEVRST, c);
    tst.scan(1'b0, 1, 32'h1, o);
    check(o[0], 1'b0);
    check(dev_rst, 1'b1);
    rchk(`OFF_RCS, FL, `RESP_OKAY);
    wr(`OFF_RCS, 32'h0, r);
    rchk(`OFF_RCS, FL, `RESP_OKAY);
    tst.scan(1'b0, 1, 32'h0, o);
    check(o[0], 1'b1);
    check(dev_rst, 1'b0);
    rchk(`OFF_RCS, FL, `RESP_OKAY);
    wr(`OFF_RCS, 32'h0, r);
    rchk(`OFF_RCS, 32'h0, `RESP_OKAY);
    tst.scan(1'b0, 1, 32'h1, o);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk(`OFF_RCS, 32'h0, `RESP_OKAY);
    tst.go_idle();
    tst.scan(1'b0, `ID_W, 32'h0, o);
    check(o, ID);
    $display("test device reset done");
    wr(8'h40, $random(seed), r);
    check(r, `RESP_SLVERR);
    rchk(8'h40, 32'h0, `RESP_SLVERR);
    $display("test unmapped done");
    end_sim();
  end
endmodule : test_boundary_scan_instructions
